// ===== include/mcrb_pkg.sv
package mcrb_pkg;

   // register offsets
   localparam logic [15:0] ADDR_MEAS_MODE   = 16'he700;
   localparam logic [15:0] ADDR_ACCUM_MODE  = 16'he701;
   localparam logic [15:0] ADDR_LCYC_MODE   = 16'he702;
   localparam logic [15:0] ADDR_PEAK_WIN    = 16'he703;
   localparam logic [15:0] ADDR_SAG_WIN     = 16'he704;
   localparam logic [15:0] ADDR_PULSE_LATCH = 16'he705;
   localparam logic [15:0] ADDR_CAPT_CFG    = 16'he706;
   localparam logic [15:0] ADDR_DIE_VER     = 16'he707;
   localparam logic [15:0] ADDR_FE_CFG      = 16'he708;
   localparam logic [15:0] ADDR_TEMP_A      = 16'he709;
   localparam logic [15:0] ADDR_TEMP_B      = 16'he70a;
   localparam logic [15:0] ADDR_TEMP_C      = 16'he70b;
   localparam logic [15:0] ADDR_TEMP_N      = 16'he70c;
   localparam logic [15:0] ADDR_KEY_FIRST   = 16'he7e3;
   localparam logic [15:0] ADDR_LAST8       = 16'he7fd;
   localparam logic [15:0] ADDR_KEY_SECOND  = 16'he7fe;
   localparam logic [15:0] ADDR_PF_A        = 16'he902;
   localparam logic [15:0] ADDR_PF_B        = 16'he903;
   localparam logic [15:0] ADDR_PF_C        = 16'he904;
   localparam logic [15:0] ADDR_PER_A       = 16'he905;
   localparam logic [15:0] ADDR_PER_B       = 16'he906;
   localparam logic [15:0] ADDR_PER_C       = 16'he907;
   localparam logic [15:0] ADDR_AP_NOLOAD   = 16'he908;

   // reset values
   localparam logic [7:0]  RST_MEAS_MODE    = 8'h1c;
   localparam logic [7:0]  RST_ACCUM_MODE   = 8'h80;
   localparam logic [7:0]  RST_LCYC_MODE    = 8'h78;
   localparam logic [7:0]  RST_PEAK_WIN     = 8'h00;
   localparam logic [7:0]  RST_SAG_WIN      = 8'h00;
   localparam logic [7:0]  RST_PULSE_LATCH  = 8'h01;
   localparam logic [7:0]  RST_CAPT_CFG     = 8'h00;
   localparam logic [7:0]  RST_FE_CFG       = 8'h0f;
   localparam logic [7:0]  RST_KEY          = 8'h00;
   localparam logic [7:0]  RST_LAST8        = 8'h00;
   localparam logic [15:0] RST_AP_NOLOAD    = 16'h0000;
   localparam logic [15:0] DATA_ZERO        = 16'h0000;

   // host request taken from the serial port engine
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mcrb_req_t;

   // answer: ok marks a mapped location, wide marks a 16-bit transfer
   typedef struct packed {
      logic        ok;
      logic        wide;
      logic [15:0] data;
   } mcrb_resp_t;

   // writable configuration seen by the metering datapath
   typedef struct packed {
      logic [7:0]  measurement_mode;
      logic [7:0]  accumulation_mode;
      logic [7:0]  line_cycle_accum_mode;
      logic [7:0]  peak_window_half_cycles;
      logic [7:0]  sag_window_half_cycles;
      logic [7:0]  pulses_per_energy_latch;
      logic [7:0]  capture_port_config;
      logic [7:0]  frontend_config;
      logic [7:0]  ram_protect_key_first;
      logic [7:0]  ram_protect_key_second;
      logic [15:0] active_power_noload_threshold;
   } mcrb_cfg_t;

   // read-only results from the datapath and front ends
   typedef struct packed {
      logic [7:0]  phase_a_temp_offset;
      logic [7:0]  phase_b_temp_offset;
      logic [7:0]  phase_c_temp_offset;
      logic [7:0]  neutral_temp_offset;
      logic [15:0] phase_a_power_factor;
      logic [15:0] phase_b_power_factor;
      logic [15:0] phase_c_power_factor;
      logic [15:0] phase_a_line_period;
      logic [15:0] phase_b_line_period;
      logic [15:0] phase_c_line_period;
   } mcrb_meas_t;

endpackage : mcrb_pkg

// ===== src/mcrb_register_bank.sv
`timescale 1ns/1ps

module mcrb_register_bank #(
   parameter logic [7:0] P_DIE_VERSION  = 8'h01, // arbitrary value
   parameter logic [7:0] P_KEY_FIRST    = 8'h5a, // arbitrary unlock value
   parameter logic [7:0] P_KEY_SECOND   = 8'ha5  // arbitrary unlock value
) (
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst,
   input  wire logic               i_req,
   input  wire mcrb_pkg::mcrb_req_t  i_req_info,
   input  wire mcrb_pkg::mcrb_meas_t i_meas,
   output logic                    o_ack,
   output mcrb_pkg::mcrb_resp_t    o_resp,
   output mcrb_pkg::mcrb_cfg_t     o_cfg,
   output logic [7:0]              o_last_byte_data,
   output logic                    o_ram_protect_off
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   mcrb_pkg::mcrb_cfg_t  cfg;
   mcrb_pkg::mcrb_cfg_t  next_cfg;
   mcrb_pkg::mcrb_resp_t resp;
   mcrb_pkg::mcrb_resp_t next_resp;
   logic                 ack;
   logic                 next_ack;
   logic [7:0]           last8;
   logic [7:0]           next_last8;
   logic                 prot_off;
   logic                 next_prot_off;

   // address decode results
   logic                 hit8;
   logic                 hit16;
   logic                 ro;
   logic [15:0]          rd_val;

   ////////////////////////////////////////////////////////////////////////////
   // decode: width, access kind and read value of the addressed register
   always_comb begin
      hit8   = 1'b1;
      hit16  = 1'b0;
      ro     = 1'b0;
      rd_val = mcrb_pkg::DATA_ZERO;
      case (i_req_info.addr)
         mcrb_pkg::ADDR_MEAS_MODE:   rd_val = {8'h00, cfg.measurement_mode};
         mcrb_pkg::ADDR_ACCUM_MODE:  rd_val = {8'h00, cfg.accumulation_mode};
         mcrb_pkg::ADDR_LCYC_MODE:   rd_val = {8'h00, cfg.line_cycle_accum_mode};
         mcrb_pkg::ADDR_PEAK_WIN:    rd_val = {8'h00, cfg.peak_window_half_cycles};
         mcrb_pkg::ADDR_SAG_WIN:     rd_val = {8'h00, cfg.sag_window_half_cycles};
         mcrb_pkg::ADDR_PULSE_LATCH: rd_val = {8'h00, cfg.pulses_per_energy_latch};
         mcrb_pkg::ADDR_CAPT_CFG:    rd_val = {8'h00, cfg.capture_port_config};
         mcrb_pkg::ADDR_DIE_VER: begin
            ro     = 1'b1;
            rd_val = {8'h00, P_DIE_VERSION};
         end
         mcrb_pkg::ADDR_FE_CFG:      rd_val = {8'h00, cfg.frontend_config};
         mcrb_pkg::ADDR_TEMP_A: begin
            ro     = 1'b1;
            rd_val = {8'h00, i_meas.phase_a_temp_offset};
         end
         mcrb_pkg::ADDR_TEMP_B: begin
            ro     = 1'b1;
            rd_val = {8'h00, i_meas.phase_b_temp_offset};
         end
         mcrb_pkg::ADDR_TEMP_C: begin
            ro     = 1'b1;
            rd_val = {8'h00, i_meas.phase_c_temp_offset};
         end
         mcrb_pkg::ADDR_TEMP_N: begin
            ro     = 1'b1;
            rd_val = {8'h00, i_meas.neutral_temp_offset};
         end
         mcrb_pkg::ADDR_KEY_FIRST:   rd_val = {8'h00, cfg.ram_protect_key_first};
         mcrb_pkg::ADDR_KEY_SECOND:  rd_val = {8'h00, cfg.ram_protect_key_second};
         mcrb_pkg::ADDR_LAST8: begin
            ro     = 1'b1;
            rd_val = {8'h00, last8};
         end
         default: begin
            hit8 = 1'b0;
            hit16 = 1'b1;
            case (i_req_info.addr)
               mcrb_pkg::ADDR_PF_A: begin
                  ro     = 1'b1;
                  rd_val = i_meas.phase_a_power_factor;
               end
               mcrb_pkg::ADDR_PF_B: begin
                  ro     = 1'b1;
                  rd_val = i_meas.phase_b_power_factor;
               end
               mcrb_pkg::ADDR_PF_C: begin
                  ro     = 1'b1;
                  rd_val = i_meas.phase_c_power_factor;
               end
               mcrb_pkg::ADDR_PER_A: begin
                  ro     = 1'b1;
                  rd_val = i_meas.phase_a_line_period;
               end
               mcrb_pkg::ADDR_PER_B: begin
                  ro     = 1'b1;
                  rd_val = i_meas.phase_b_line_period;
               end
               mcrb_pkg::ADDR_PER_C: begin
                  ro     = 1'b1;
                  rd_val = i_meas.phase_c_line_period;
               end
               mcrb_pkg::ADDR_AP_NOLOAD: rd_val = cfg.active_power_noload_threshold;
               // reserved space reads zero and reports no success
               default:  hit16 = 1'b0;
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next register values from a host request
   always_comb begin
      next_cfg      = cfg;
      next_last8    = last8;
      next_ack      = i_req;
      next_resp     = resp;
      if (i_req) begin
         next_resp.ok   = hit8 | hit16;
         next_resp.wide = hit16;
         next_resp.data = i_req_info.wr ? mcrb_pkg::DATA_ZERO : rd_val;
      end
      // writes land only on read/write registers
      if (i_req && i_req_info.wr && !ro) begin
         case (i_req_info.addr)
            mcrb_pkg::ADDR_MEAS_MODE:   next_cfg.measurement_mode        = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_ACCUM_MODE:  next_cfg.accumulation_mode       = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_LCYC_MODE:   next_cfg.line_cycle_accum_mode   = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_PEAK_WIN:    next_cfg.peak_window_half_cycles = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_SAG_WIN:     next_cfg.sag_window_half_cycles  = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_PULSE_LATCH: next_cfg.pulses_per_energy_latch = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_CAPT_CFG:    next_cfg.capture_port_config     = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_FE_CFG:      next_cfg.frontend_config         = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_KEY_FIRST:   next_cfg.ram_protect_key_first   = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_KEY_SECOND:  next_cfg.ram_protect_key_second  = i_req_info.wdata[7:0];
            mcrb_pkg::ADDR_AP_NOLOAD:   next_cfg.active_power_noload_threshold = i_req_info.wdata;
            default:                    next_cfg = cfg;
         endcase
      end
      if (i_req && hit8 && !(i_req_info.wr && ro)) begin
         next_last8 = i_req_info.wr ? i_req_info.wdata[7:0] : rd_val[7:0];
      end
      next_prot_off = (next_cfg.ram_protect_key_first == P_KEY_FIRST) &&
                      (next_cfg.ram_protect_key_second == P_KEY_SECOND);
   end

   ////////////////////////////////////////////////////////////////////////////
   // register stage with synchronous reset
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cfg.measurement_mode              <= mcrb_pkg::RST_MEAS_MODE;
         cfg.accumulation_mode             <= mcrb_pkg::RST_ACCUM_MODE;
         cfg.line_cycle_accum_mode         <= mcrb_pkg::RST_LCYC_MODE;
         cfg.peak_window_half_cycles       <= mcrb_pkg::RST_PEAK_WIN;
         cfg.sag_window_half_cycles        <= mcrb_pkg::RST_SAG_WIN;
         cfg.pulses_per_energy_latch       <= mcrb_pkg::RST_PULSE_LATCH;
         cfg.capture_port_config           <= mcrb_pkg::RST_CAPT_CFG;
         cfg.frontend_config               <= mcrb_pkg::RST_FE_CFG;
         cfg.ram_protect_key_first         <= mcrb_pkg::RST_KEY;
         cfg.ram_protect_key_second        <= mcrb_pkg::RST_KEY;
         cfg.active_power_noload_threshold <= mcrb_pkg::RST_AP_NOLOAD;
         last8                             <= mcrb_pkg::RST_LAST8;
         ack                               <= 1'b0;
         resp                              <= '0;
         prot_off                          <= 1'b0;
      end else begin
         cfg      <= next_cfg;
         last8    <= next_last8;
         ack      <= next_ack;
         resp     <= next_resp;
         prot_off <= next_prot_off;
      end
   end

   // outputs straight from flops
   assign o_ack             = ack;
   assign o_resp            = resp;
   assign o_cfg             = cfg;
   assign o_last_byte_data  = last8;
   assign o_ram_protect_off = prot_off;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_wr(logic [15:0] a);
      i_req && i_req_info.wr && (i_req_info.addr == a);
   endsequence

   sequence s_rd(logic [15:0] a);
      i_req && !i_req_info.wr && (i_req_info.addr == a);
   endsequence

   property p_rst_values;
      @(posedge i_ref_clk) i_rst |=> (cfg.measurement_mode == mcrb_pkg::RST_MEAS_MODE) &&
         (cfg.accumulation_mode == mcrb_pkg::RST_ACCUM_MODE) &&
         (cfg.line_cycle_accum_mode == mcrb_pkg::RST_LCYC_MODE) &&
         (cfg.pulses_per_energy_latch == mcrb_pkg::RST_PULSE_LATCH) &&
         (cfg.frontend_config == mcrb_pkg::RST_FE_CFG);
   endproperty
   a_rst_values: assert property (p_rst_values) else $error("reset value wrong");

   property p_meas_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_MEAS_MODE) |=> cfg.measurement_mode == $past(i_req_info.wdata[7:0]);
   endproperty
   a_meas_wr: assert property (p_meas_wr) else $error("mode write lost");

   property p_noload_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_AP_NOLOAD) |=> o_cfg.active_power_noload_threshold == $past(i_req_info.wdata);
   endproperty
   a_noload_wr: assert property (p_noload_wr) else $error("threshold write lost");

   property p_ro_ignored;
      @(posedge i_ref_clk) disable iff (i_rst)
         (i_req && i_req_info.wr && ro) |=> $stable(cfg);
   endproperty
   a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write changed state");

   property p_readback;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_SAG_WIN) ##1 !i_req ##1 s_rd(mcrb_pkg::ADDR_SAG_WIN)
         |=> o_ack && o_resp.data[7:0] == $past(i_req_info.wdata[7:0], 3);
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch");

   property p_width;
      @(posedge i_ref_clk) disable iff (i_rst)
         (i_req && i_req_info.addr == mcrb_pkg::ADDR_PF_A) |=> o_ack && o_resp.ok && o_resp.wide;
   endproperty
   a_width: assert property (p_width) else $error("wide transfer not flagged");

   property p_echo;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_PEAK_WIN) |=> o_last_byte_data == $past(i_req_info.wdata[7:0]);
   endproperty
   a_echo: assert property (p_echo) else $error("echo not captured");

   property p_keys;
      @(posedge i_ref_clk) disable iff (i_rst)
         o_ram_protect_off |-> (cfg.ram_protect_key_first == P_KEY_FIRST) &&
                               (cfg.ram_protect_key_second == P_KEY_SECOND);
   endproperty
   a_keys: assert property (p_keys) else $error("protection lifted without keys");

   property p_period;
      @(posedge i_ref_clk) disable iff (i_rst)
         (i_req && !i_req_info.wr && i_req_info.addr == mcrb_pkg::ADDR_PER_B)
         |=> o_resp.data == $past(i_meas.phase_b_line_period);
   endproperty
   a_period: assert property (p_period) else $error("period read wrong");

   property p_temp;
      @(posedge i_ref_clk) disable iff (i_rst)
         (i_req && !i_req_info.wr && i_req_info.addr == mcrb_pkg::ADDR_TEMP_N)
         |=> o_resp.data[7:0] == $past(i_meas.neutral_temp_offset) && !o_resp.wide;
   endproperty
   a_temp: assert property (p_temp) else $error("temperature offset read wrong");

   property p_ack_follow;
      @(posedge i_ref_clk) disable iff (i_rst)
         i_req |=> o_ack;
   endproperty
   a_ack_follow: assert property (p_ack_follow) else $error("request not answered");

   property p_ack_quiet;
      @(posedge i_ref_clk) disable iff (i_rst)
         !i_req |=> !o_ack && $stable(o_resp);
   endproperty
   a_ack_quiet: assert property (p_ack_quiet) else $error("answer moved without request");

   property p_wr_answer;
      @(posedge i_ref_clk) disable iff (i_rst)
         (i_req && i_req_info.wr) |=> o_resp.data == mcrb_pkg::DATA_ZERO;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer carries data");

   property p_reserved;
      @(posedge i_ref_clk) disable iff (i_rst)
         (i_req && i_req_info.addr > mcrb_pkg::ADDR_TEMP_N && i_req_info.addr < mcrb_pkg::ADDR_KEY_FIRST)
         |=> o_ack && !o_resp.ok && o_resp.data == mcrb_pkg::DATA_ZERO && $stable(o_cfg);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved location answered");

   property p_rst_windows;
      @(posedge i_ref_clk) i_rst |=> (cfg.peak_window_half_cycles == mcrb_pkg::RST_PEAK_WIN) &&
         (cfg.sag_window_half_cycles == mcrb_pkg::RST_SAG_WIN) &&
         (cfg.capture_port_config == mcrb_pkg::RST_CAPT_CFG) &&
         (cfg.active_power_noload_threshold == mcrb_pkg::RST_AP_NOLOAD) &&
         (o_last_byte_data == mcrb_pkg::RST_LAST8) && !o_ram_protect_off && !o_ack;
   endproperty
   a_rst_windows: assert property (p_rst_windows) else $error("window reset value wrong");

   property p_accum_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_ACCUM_MODE) |=> cfg.accumulation_mode == $past(i_req_info.wdata[7:0]);
   endproperty
   a_accum_wr: assert property (p_accum_wr) else $error("accumulation mode write lost");

   property p_lcyc_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_LCYC_MODE) |=> cfg.line_cycle_accum_mode == $past(i_req_info.wdata[7:0]);
   endproperty
   a_lcyc_wr: assert property (p_lcyc_wr) else $error("line-cycle mode write lost");

   property p_sag_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_SAG_WIN) |=> cfg.sag_window_half_cycles == $past(i_req_info.wdata[7:0]);
   endproperty
   a_sag_wr: assert property (p_sag_wr) else $error("sag window write lost");

   property p_pulse_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_PULSE_LATCH) |=> cfg.pulses_per_energy_latch == $past(i_req_info.wdata[7:0]);
   endproperty
   a_pulse_wr: assert property (p_pulse_wr) else $error("pulse count write lost");

   property p_capt_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_CAPT_CFG) |=> cfg.capture_port_config == $past(i_req_info.wdata[7:0]);
   endproperty
   a_capt_wr: assert property (p_capt_wr) else $error("capture config write lost");

   property p_fe_wr;
      @(posedge i_ref_clk) disable iff (i_rst)
         s_wr(mcrb_pkg::ADDR_FE_CFG) |=> cfg.frontend_config == $past(i_req_info.wdata[7:0]);
   endproperty
   a_fe_wr: assert property (p_fe_wr) else $error("front-end config write lost");

endmodule : mcrb_register_bank

// ===== verif/mcrb_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host processor standing for the serial engine on the request port
module mcrb_host_model (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_ack,
   input  wire mcrb_pkg::mcrb_resp_t i_resp,
   output mcrb_pkg::mcrb_req_t       o_req_info,
   output logic                      o_req
);
   ////////////////////////////////////////////////////////////////////////////
   // idle port: qualifiers never rest on a stale value
   initial begin
      o_req      = 1'b0;
      o_req_info = '{wr: 1'b0, addr: 16'hffff, wdata: 16'hffff};
   end

   // reserved holes of the map
   function automatic logic is_reserved(input logic [15:0] addr);
      return (addr >= 16'he70d && addr <= 16'he7e2) || (addr >= 16'he7e4 && addr <= 16'he7fc) ||
             (addr >= 16'he7ff && addr <= 16'he901);
   endfunction : is_reserved

   // one-cycle request off the falling edge, answer taken at a bounded wait
   task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                       output mcrb_pkg::mcrb_resp_t resp, output logic got);
      int n;
      got  = 1'b0;
      resp = '0;
      if (wr && is_reserved(addr)) return;
      @(negedge i_ref_clk);
      o_req      = 1'b1;
      o_req_info = '{wr: wr, addr: addr, wdata: wdata};
      @(negedge i_ref_clk);
      o_req      = 1'b0;
      o_req_info = '{wr: ~wr, addr: ~addr, wdata: ~wdata}; // scrambled after release
      for (n = 0; n < 4 && !got; n++) begin
         if (i_ack === 1'b1) begin
            got  = 1'b1;
            resp = i_resp;
         end else @(negedge i_ref_clk);
      end
   endtask : xfer
endmodule : mcrb_host_model

// ===== verif/test_metering_config_register_bank.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module test_metering_config_register_bank;
   logic                 i_ref_clk = 1'b0;
   logic                 i_rst     = 1'b1;
   logic                 req;
   mcrb_pkg::mcrb_req_t  req_info;
   mcrb_pkg::mcrb_meas_t meas;
   logic                 ack;
   mcrb_pkg::mcrb_resp_t resp;
   mcrb_pkg::mcrb_cfg_t  cfg;
   logic [7:0]           last8;
   logic                 prot_off;
   int                   n_fail = 0;
   int                   checks = 0;
   int                   cyc    = 0;

   // writable map with reset values, wide entry last
   localparam logic [15:0] RW_ADDR [11] = '{16'he700, 16'he701, 16'he702, 16'he703, 16'he704, 16'he705,
                                           16'he706, 16'he708, 16'he7e3, 16'he7fe, 16'he908};
   localparam logic [15:0] RW_RST  [11] = '{16'h001c, 16'h0080, 16'h0078, 16'h0000, 16'h0000, 16'h0001,
                                           16'h0000, 16'h000f, 16'h0000, 16'h0000, 16'h0000};
   // read-only map and the values fed on the results inputs
   localparam logic [15:0] RO_ADDR [10] = '{16'he709, 16'he70a, 16'he70b, 16'he70c, 16'he902, 16'he903,
                                           16'he904, 16'he905, 16'he906, 16'he907};
   localparam logic [15:0] RO_EXP  [10] = '{16'h0081, 16'h007f, 16'h00f0, 16'h0005, 16'h4001, 16'h8002,
                                           16'hc003, 16'h1f40, 16'h1f41, 16'h1f42};

   ////////////////////////////////////////////////////////////////////////////
   // clock, design and host
   always #25 i_ref_clk = ~i_ref_clk;

   mcrb_register_bank u_dut (
      .i_ref_clk         (i_ref_clk),
      .i_rst             (i_rst),
      .i_req             (req),
      .i_req_info        (req_info),
      .i_meas            (meas),
      .o_ack             (ack),
      .o_resp            (resp),
      .o_cfg             (cfg),
      .o_last_byte_data  (last8),
      .o_ram_protect_off (prot_off)
   );

   mcrb_host_model u_host (
      .i_ref_clk  (i_ref_clk),
      .i_ack      (ack),
      .i_resp     (resp),
      .o_req_info (req_info),
      .o_req      (req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // verdict and hang guard
   task automatic test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done

   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end

   // value comparison
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // one access with answer flags checked; 8-bit data seen in the low byte
   task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                         input logic ok, input logic wide, input logic [15:0] exp);
      mcrb_pkg::mcrb_resp_t r;
      logic                 got;
      u_host.xfer(wr, addr, wdata, r, got);
      cmp("ack", 16'h0001, {15'h0000, got});
      cmp("ok", {15'h0000, ok}, {15'h0000, r.ok});
      cmp("wide", {15'h0000, wide}, {15'h0000, r.wide});
      cmp("data", exp, wide ? r.data : {8'h00, r.data[7:0]});
   endtask : access

   // reset held ten cycles, then every writable place read back
   task automatic reset_and_check;
      i_rst = 1'b1;
      repeat (10) @(negedge i_ref_clk);
      i_rst = 1'b0;
      cmp("echo", 16'h0000, {8'h00, last8});
      cmp("protect", 16'h0000, {15'h0000, prot_off});
      for (int i = 0; i < 11; i++) access(1'b0, RW_ADDR[i], 16'h0000, 1'b1, i == 10, RW_RST[i]);
   endtask : reset_and_check

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [15:0] v;
      meas = '{8'h81, 8'h7f, 8'hf0, 8'h05, 16'h4001, 16'h8002, 16'hc003, 16'h1f40, 16'h1f41, 16'h1f42};
      reset_and_check();
      // write each writable place, echo for the 8-bit places only and readback one idle cycle after the write
      for (int i = 0; i < 11; i++) begin
         v = (i == 10) ? 16'hbe5f : {8'h00, 8'ha0 + 8'(i)};
         access(1'b1, RW_ADDR[i], v, 1'b1, i == 10, 16'h0000);
         if (i < 10) cmp("echo", v, {8'h00, last8});
         access(1'b0, RW_ADDR[i], 16'h0000, 1'b1, i == 10, v);
      end
      cmp("echo", 16'h00a9, {8'h00, last8});
      cmp("peak", 16'h00a3, {8'h00, cfg.peak_window_half_cycles});
      cmp("noload", 16'hbe5f, cfg.active_power_noload_threshold);
      // read-only results, then writes to them that must not land
      for (int i = 0; i < 10; i++) access(1'b0, RO_ADDR[i], 16'h0000, 1'b1, i > 3, RO_EXP[i]);
      access(1'b1, 16'he709, 16'h0033, 1'b1, 1'b0, 16'h0000);
      cmp("echo", 16'h0005, {8'h00, last8});
      access(1'b0, 16'he709, 16'h0000, 1'b1, 1'b0, 16'h0081);
      access(1'b1, 16'he902, 16'hdead, 1'b1, 1'b1, 16'h0000);
      access(1'b0, 16'he902, 16'h0000, 1'b1, 1'b1, 16'h4001);
      access(1'b0, 16'he7fd, 16'h0000, 1'b1, 1'b0, 16'h0081);
      access(1'b0, 16'he707, 16'h0000, 1'b1, 1'b0, 16'h0001);
      // reserved holes answer not mapped
      access(1'b0, 16'he70d, 16'h0000, 1'b0, 1'b0, 16'h0000);
      access(1'b0, 16'he800, 16'h0000, 1'b0, 1'b0, 16'h0000);
      // both keys open the ram protection, one wrong key closes it
      access(1'b1, 16'he7e3, 16'h005a, 1'b1, 1'b0, 16'h0000);
      access(1'b1, 16'he7fe, 16'h00a5, 1'b1, 1'b0, 16'h0000);
      access(1'b0, 16'he7fe, 16'h0000, 1'b1, 1'b0, 16'h00a5);
      cmp("protect", 16'h0001, {15'h0000, prot_off});
      access(1'b1, 16'he7fe, 16'h0000, 1'b1, 1'b0, 16'h0000);
      access(1'b0, 16'he7e3, 16'h0000, 1'b1, 1'b0, 16'h005a);
      cmp("protect", 16'h0000, {15'h0000, prot_off});
      // second reset in mid-run
      reset_and_check();
      test_done();
   end
endmodule : test_metering_config_register_bank
